// [cpu_status_product_path.v]
// Notes on behaviour
// - product register is 32 bits, holds full signed or unsigned 16x16 product
// - product shifter passes unshifted, left one, left four, or right six
// - shifter sits after product register, feeding ALU and write bus, no cycle
// - stack holds eight 16-bit entries for return addresses or pushed data
// - temp register feeds multiplier, dynamic shift count and dynamic bit index
// - program and data paths are separate so fetch and data read coincide
// - pipelined core completes most operations at one per cycle
// - both status words load from and store to data memory
// - set and clear flag operations change one bit only
// - reserved status bits always read as one
// - pointer load copies old pointer into backup, except status loads
// - loading status word one copies backup value into pointer too
// - pointer picks auxiliary register; changed by indirect, load, modify, status load
// - carry set on add carry else cleared; cleared on borrow else set
// - add/sub with 16-bit shift may only set or only clear carry
// - carry also from shifts, set/clear and status word one loads; reset sets it
// - 9-bit page pointer above seven instruction bits forms direct address
// - mask zero enables unmasked maskable interrupts; one blocks them
// - mask set by reset, acknowledge and maskable trap; set/clear flag ops too
// - status loads never change the interrupt mask
// - shift mode encoding 00 none, 01 left1, 10 left4, 11 right6 signed
`timescale 1ns/1ps
`include "cpu_status_defs.vh"

module cpu_status_product_path (
  input wire clk_sys,
  input wire rst_b,
  input wire opValid,
  input wire [4:0] opCode,
  input wire [1:0] flagSelect,
  input wire [15:0] opData,
  input wire aluCarry,
  input wire [6:0] instrLow,
  input wire [15:0] progFetchData,
  input wire irqAcknowledge,
  input wire trapTaken,
  input wire irqPending,
  output reg [15:0] readData_q,
  output reg readValid_q,
  output reg [31:0] productScaled_q,
  output reg [31:0] productRaw_q,
  output reg [15:0] tempReg_q,
  output reg [3:0] dynShiftCount_q,
  output reg [3:0] dynBitIndex_q,
  output reg [2:0] auxPointer_q,
  output reg [2:0] auxPointerBackup_q,
  output reg [8:0] pagePointer_q,
  output reg [15:0] directAddr_q,
  output reg [1:0] productShiftMode_q,
  output reg carryFlag_q,
  output reg ramMapSelect_q,
  output reg globalIrqMask_q,
  output reg irqEnable_q,
  output reg [15:0] instrWord_q,
  output reg [2:0] stackDepth_q
);

  reg [31:0] productD;
  reg [15:0] tempD;
  reg [2:0] arpD;
  reg [2:0] arbD;
  reg [8:0] dpD;
  reg [1:0] pmD;
  reg carryD;
  reg cnfD;
  reg intmD;
  reg [15:0] statusZero;
  reg [15:0] statusOne;
  reg [15:0] stackMem [0:`STACK_DEPTH-1];
  reg [`STACK_PTR_W-1:0] stackPtr_q;
  reg [`STACK_PTR_W-1:0] stackPtrD;
  reg [`STACK_PTR_W-1:0] popIdx;
  wire [31:0] shiftedD;
  wire [31:0] signedProd;
  wire [31:0] unsignedProd;
  wire isOp;
  integer i;

  assign isOp = opValid;

  // 16x16 products, temp register supplies one operand
  assign signedProd = $signed(tempReg_q) * $signed(opData);
  assign unsignedProd = tempReg_q * opData;

  // scaled product computed from next state so the registered output needs no extra cycle
  product_shifter uShift (
    .productIn(productD),
    .shiftMode(pmD),
    .productOut(shiftedD)
  );

  // status words as read, reserved positions forced to one
  always @* begin
    statusZero = `ST0_RSVD_MASK;
    statusZero[`ST0_ARP_HI:`ST0_ARP_LO] = auxPointer_q;
    statusZero[`ST0_GLOBAL_IRQ_MASK] = globalIrqMask_q;
    statusZero[`ST0_DP_HI:`ST0_DP_LO] = pagePointer_q;
    statusOne = `ST1_RSVD_MASK;
    statusOne[`ST1_ARB_HI:`ST1_ARB_LO] = auxPointerBackup_q;
    statusOne[`ST1_CNF] = ramMapSelect_q;
    statusOne[`ST1_CARRY] = carryFlag_q;
    statusOne[`ST1_PM_HI:`ST1_PM_LO] = productShiftMode_q;
  end

  // next product and temp register
  always @* begin
    productD = productRaw_q;
    tempD = tempReg_q;
    if (isOp) begin
      case (opCode)
        `OP_LDTEMP: tempD = opData;
        `OP_MPYS: productD = signedProd;
        `OP_MPYU: productD = unsignedProd;
        `OP_LDPROD: productD = {opData, productRaw_q[15:0]};
        default: productD = productRaw_q;
      endcase
    end
  end

  // next auxiliary pointer, backup and page pointer
  always @* begin
    arpD = auxPointer_q;
    arbD = auxPointerBackup_q;
    dpD = pagePointer_q;
    if (isOp) begin
      case (opCode)
        `OP_LDPTR, `OP_MODAUX, `OP_INDIRECT: begin
          arpD = opData[2:0];
          arbD = auxPointer_q;
        end
        `OP_LST0: begin
          arpD = opData[`ST0_ARP_HI:`ST0_ARP_LO];
          dpD = opData[`ST0_DP_HI:`ST0_DP_LO];
        end
        `OP_LST1: begin
          arbD = opData[`ST1_ARB_HI:`ST1_ARB_LO];
          arpD = opData[`ST1_ARB_HI:`ST1_ARB_LO];
        end
        `OP_LDPAGE: dpD = opData[8:0];
        default: arpD = auxPointer_q;
      endcase
    end
  end

  // next carry, map select and shift mode
  always @* begin
    carryD = carryFlag_q;
    cnfD = ramMapSelect_q;
    pmD = productShiftMode_q;
    if (isOp) begin
      case (opCode)
        `OP_ADD, `OP_SUB: carryD = aluCarry;
        `OP_ADD16: begin
          if (aluCarry) begin
            carryD = 1'b1;
          end
        end
        `OP_SUB16: begin
          if (!aluCarry) begin
            carryD = 1'b0;
          end
        end
        `OP_SHIFT: carryD = aluCarry;
        `OP_SETF, `OP_CLRF: begin
          if (flagSelect == `FLAG_CARRY) begin
            carryD = (opCode == `OP_SETF);
          end
          if (flagSelect == `FLAG_CNF) begin
            cnfD = (opCode == `OP_SETF);
          end
        end
        `OP_LST1: begin
          carryD = opData[`ST1_CARRY];
          cnfD = opData[`ST1_CNF];
          pmD = opData[`ST1_PM_HI:`ST1_PM_LO];
        end
        `OP_SETPM: pmD = opData[1:0];
        default: carryD = carryFlag_q;
      endcase
    end
  end

  // next interrupt mask, hardware set wins over a clear in the same cycle
  always @* begin
    intmD = globalIrqMask_q;
    if (isOp && (flagSelect == `FLAG_GLOBAL_IRQ_MASK)) begin
      if (opCode == `OP_SETF) begin
        intmD = 1'b1;
      end else if (opCode == `OP_CLRF) begin
        intmD = 1'b0;
      end
    end
    if (irqAcknowledge || trapTaken) begin
      intmD = 1'b1;
    end
  end

  // stack pointer movement and pop index
  always @* begin
    stackPtrD = stackPtr_q;
    popIdx = stackPtr_q - 3'h1;
    if (isOp && (opCode == `OP_PUSH)) begin
      stackPtrD = stackPtr_q + 3'h1;
    end else if (isOp && (opCode == `OP_POP)) begin
      stackPtrD = popIdx;
    end
  end

  // state registers
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      productRaw_q <= 32'h0000_0000;
      productScaled_q <= 32'h0000_0000;
      tempReg_q <= 16'h0000;
      dynShiftCount_q <= 4'h0;
      dynBitIndex_q <= 4'h0;
      auxPointer_q <= `RST_ARP;
      auxPointerBackup_q <= `RST_ARB;
      pagePointer_q <= `RST_DP;
      productShiftMode_q <= `RST_PM;
      carryFlag_q <= `RST_CARRY;
      ramMapSelect_q <= `RST_CNF;
      globalIrqMask_q <= `RST_GLOBAL_IRQ_MASK;
      stackPtr_q <= 3'h0;
    end else begin
      productRaw_q <= productD;
      productScaled_q <= shiftedD;
      tempReg_q <= tempD;
      dynShiftCount_q <= tempD[3:0];
      dynBitIndex_q <= 4'hF - tempD[3:0];
      auxPointer_q <= arpD;
      auxPointerBackup_q <= arbD;
      pagePointer_q <= dpD;
      productShiftMode_q <= pmD;
      carryFlag_q <= carryD;
      ramMapSelect_q <= cnfD;
      globalIrqMask_q <= intmD;
      stackPtr_q <= stackPtrD;
    end
  end

  // stack storage, circular so the oldest entry is overwritten past eight
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
        stackMem[i] <= 16'h0000;
      end
    end else if (isOp && (opCode == `OP_PUSH)) begin
      stackMem[stackPtr_q] <= opData;
    end
  end

  // occupancy count, saturating at eight minus one for a 3-bit view
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stackDepth_q <= 3'h0;
    end else if (isOp && (opCode == `OP_PUSH) && (stackDepth_q != 3'h7)) begin
      stackDepth_q <= stackDepth_q + 3'h1;
    end else if (isOp && (opCode == `OP_POP) && (stackDepth_q != 3'h0)) begin
      stackDepth_q <= stackDepth_q - 3'h1;
    end
  end

  // read data: status stores, stack pops, one answer per operation
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      readData_q <= 16'h0000;
      readValid_q <= 1'b0;
    end else begin
      readValid_q <= 1'b0;
      if (isOp) begin
        case (opCode)
          `OP_SST0: begin
            readData_q <= statusZero;
            readValid_q <= 1'b1;
          end
          `OP_SST1: begin
            readData_q <= statusOne;
            readValid_q <= 1'b1;
          end
          `OP_POP: begin
            readData_q <= stackMem[popIdx];
            readValid_q <= 1'b1;
          end
          default: readValid_q <= 1'b0;
        endcase
      end
    end
  end

  // program fetch captured alongside any data operation in the same cycle
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      instrWord_q <= 16'h0000;
    end else begin
      instrWord_q <= progFetchData;
    end
  end

  // direct address and interrupt enable from next state
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      directAddr_q <= 16'h0000;
      irqEnable_q <= 1'b0;
    end else begin
      directAddr_q <= {dpD, instrLow};
      irqEnable_q <= irqPending & ~intmD;
    end
  end

endmodule

// [cpu_status_defs.vh]
`ifndef CPU_STATUS_DEFS_VH
`define CPU_STATUS_DEFS_VH

// operation codes presented on opCode with opValid
`define OP_NOP 5'h00
`define OP_LST0 5'h01
`define OP_LST1 5'h02
`define OP_SST0 5'h03
`define OP_SST1 5'h04
`define OP_SETF 5'h05
`define OP_CLRF 5'h06
`define OP_LDPTR 5'h07
`define OP_MODAUX 5'h08
`define OP_INDIRECT 5'h09
`define OP_LDPAGE 5'h0A
`define OP_SETPM 5'h0B
`define OP_LDTEMP 5'h0C
`define OP_MPYS 5'h0D
`define OP_MPYU 5'h0E
`define OP_ADD 5'h0F
`define OP_SUB 5'h10
`define OP_ADD16 5'h11
`define OP_SUB16 5'h12
`define OP_SHIFT 5'h13
`define OP_PUSH 5'h14
`define OP_POP 5'h15
`define OP_LDPROD 5'h16

// flag selectors for set/clear operations
`define FLAG_CARRY 2'h0
`define FLAG_CNF 2'h1
`define FLAG_GLOBAL_IRQ_MASK 2'h2

// status word zero layout
`define ST0_ARP_HI 15
`define ST0_ARP_LO 13
`define ST0_GLOBAL_IRQ_MASK 9
`define ST0_DP_HI 8
`define ST0_DP_LO 0
`define ST0_RSVD_MASK 16'h1C00

// status word one layout
`define ST1_ARB_HI 15
`define ST1_ARB_LO 13
`define ST1_CNF 12
`define ST1_CARRY 9
`define ST1_PM_HI 1
`define ST1_PM_LO 0
`define ST1_RSVD_MASK 16'h0DFC

// product shift mode encodings
`define PM_NONE 2'h0
`define PM_LEFT1 2'h1
`define PM_LEFT4 2'h2
`define PM_RIGHT6 2'h3

// reset values
`define RST_ARP 3'h0
`define RST_ARB 3'h0
`define RST_DP 9'h000
`define RST_PM 2'h0
`define RST_CARRY 1'b1
`define RST_CNF 1'b0
`define RST_GLOBAL_IRQ_MASK 1'b1

`define STACK_DEPTH 8
`define STACK_PTR_W 3

`endif

// [product_shifter.v]
`timescale 1ns/1ps
`include "cpu_status_defs.vh"

module product_shifter (
  input wire [31:0] productIn,
  input wire [1:0] shiftMode,
  output reg [31:0] productOut
);

  // combinational scaling, no added cycle
  always @* begin
    case (shiftMode)
      `PM_NONE: productOut = productIn;
      `PM_LEFT1: productOut = {productIn[30:0], 1'b0};
      `PM_LEFT4: productOut = {productIn[27:0], 4'h0};
      `PM_RIGHT6: productOut = {{6{productIn[31]}}, productIn[31:6]};
      default: productOut = productIn;
    endcase
  end

endmodule

// [cpu_status_product_path_props.sv]
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
module cpu_status_product_path_props (
  input logic clk_sys,
  input logic rst_b,
  input logic opValid,
  input logic [4:0] opCode,
  input logic [15:0] opData,
  input logic aluCarry,
  input logic irqAcknowledge,
  input logic trapTaken,
  input logic irqPending,
  input logic readValid_q,
  input logic [15:0] readData_q,
  input logic [2:0] auxPointer_q,
  input logic [2:0] auxPointerBackup_q,
  input logic carryFlag_q,
  input logic globalIrqMask_q,
  input logic irqEnable_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // operand slices and decoded requests
  wire [2:0] dLow = opData[2:0];
  wire [2:0] dHigh = opData[15:13];
  wire isLst = opValid && (opCode == `OP_LST0 || opCode == `OP_LST1) && !irqAcknowledge && !trapTaken;
  AST_RSVD_ONES: assert property (opValid && opCode == `OP_SST0 |=> readData_q[12:10] == 3'h7)
    else $error("reserved bits of word zero not one");
  AST_STORE_ONE: assert property (opValid && opCode == `OP_SST1 |=> readValid_q && readData_q[8:2] == 7'h7F)
    else $error("store of word one missing");
  AST_BACKUP_COPY: assert property (opValid && opCode == `OP_LDPTR |=>
    auxPointerBackup_q == $past(auxPointer_q) && auxPointer_q == $past(dLow))
    else $error("pointer load did not back up old pointer");
  AST_LST1_PTR: assert property (opValid && opCode == `OP_LST1 |=>
    auxPointer_q == $past(dHigh) && auxPointerBackup_q == $past(dHigh))
    else $error("word one load did not copy backup into pointer");
  AST_LST_MASK: assert property (isLst |=> globalIrqMask_q == $past(globalIrqMask_q))
    else $error("status load changed the mask");
  AST_HW_MASK: assert property (irqAcknowledge || trapTaken |=> globalIrqMask_q)
    else $error("mask not set by acknowledge or trap");
  AST_ADD_CARRY: assert property (opValid && (opCode == `OP_ADD || opCode == `OP_SUB) |=>
    carryFlag_q == $past(aluCarry))
    else $error("carry not taken from add or sub");
  AST_ADD16: assert property (opValid && opCode == `OP_ADD16 && !aluCarry |=> $stable(carryFlag_q))
    else $error("wide add cleared carry");
  AST_SUB16: assert property (opValid && opCode == `OP_SUB16 && aluCarry |=> $stable(carryFlag_q))
    else $error("wide sub set carry");
  AST_IRQ_EN: assert property (irqEnable_q == ($past(irqPending) && !globalIrqMask_q))
    else $error("interrupt enable disagrees with mask");
  // main scenarios reached
  cover property (opValid && opCode == `OP_LST1);
  cover property (irqEnable_q);
  cover property (trapTaken);
endmodule

// [cpu_status_product_path_tb_top.sv]
`timescale 1ns/1ps
`include "cpu_status_defs.vh"
module cpu_status_product_path_tb_top;
  logic clk_sys, rst_b, opValid, aluCarry, irqAcknowledge, trapTaken, irqPending;
  logic [4:0] opCode;
  logic [1:0] flagSelect, productShiftMode_q;
  logic [15:0] opData, progFetchData, readData_q, tempReg_q, directAddr_q, instrWord_q;
  logic [6:0] instrLow;
  logic readValid_q, carryFlag_q, ramMapSelect_q, globalIrqMask_q, irqEnable_q;
  logic [31:0] productScaled_q, productRaw_q;
  logic [3:0] dynShiftCount_q, dynBitIndex_q;
  logic [2:0] auxPointer_q, auxPointerBackup_q, stackDepth_q;
  logic [8:0] pagePointer_q;
  int bad_count, compares;
  // signed, mode, temp, operand, raw product, scaled product
  logic [98:0] mulRows [6] = '{
    {1'h1, 2'h0, 16'h0003, 16'hFFFE, 32'hFFFF_FFFA, 32'hFFFF_FFFA},
    {1'h1, 2'h1, 16'h0003, 16'hFFFE, 32'hFFFF_FFFA, 32'hFFFF_FFF4},
    {1'h1, 2'h2, 16'h0003, 16'hFFFE, 32'hFFFF_FFFA, 32'hFFFF_FFA0},
    {1'h1, 2'h3, 16'h0003, 16'hFFFE, 32'hFFFF_FFFA, 32'hFFFF_FFFF},
    {1'h0, 2'h3, 16'h0003, 16'hFFFE, 32'h0002_FFFA, 32'h0000_0BFF},
    {1'h1, 2'h1, 16'h8000, 16'h8000, 32'h4000_0000, 32'h8000_0000}};
  // opcode, alu carry, expected carry flag
  logic [6:0] carryRows [11] = '{{`OP_ADD, 2'h0}, {`OP_ADD, 2'h3}, {`OP_ADD16, 2'h1}, {`OP_SUB16, 2'h0},
    {`OP_SUB16, 2'h2}, {`OP_ADD16, 2'h3}, {`OP_SUB, 2'h0}, {`OP_SUB, 2'h3}, {`OP_SHIFT, 2'h0},
    {`OP_SETF, 2'h1}, {`OP_CLRF, 2'h0}};

  cpu_status_product_path uut (.clk_sys, .rst_b, .opValid, .opCode, .flagSelect, .opData, .aluCarry,
    .instrLow, .progFetchData, .irqAcknowledge, .trapTaken, .irqPending, .readData_q, .readValid_q,
    .productScaled_q, .productRaw_q, .tempReg_q, .dynShiftCount_q, .dynBitIndex_q, .auxPointer_q,
    .auxPointerBackup_q, .pagePointer_q, .directAddr_q, .productShiftMode_q, .carryFlag_q,
    .ramMapSelect_q, .globalIrqMask_q, .irqEnable_q, .instrWord_q, .stackDepth_q);

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic op(input logic [4:0] c, input logic [15:0] d, input logic k, input logic [1:0] f);
    @(posedge clk_sys);
    opValid <= 1'h1;
    opCode <= c;
    opData <= d;
    aluCarry <= k;
    flagSelect <= f;
  endtask

  // release strobes at the taking edge and let its updates land
  task automatic settle;
    @(posedge clk_sys);
    opValid <= 1'h0;
    irqAcknowledge <= 1'h0;
    trapTaken <= 1'h0;
    #1;
  endtask

  task automatic complete_run;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // core clock
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard
  initial begin
    #40000;
    bad_count++;
    complete_run;
  end

  // main sequence
  initial begin
    {rst_b, opValid, aluCarry, irqAcknowledge, trapTaken, opCode, flagSelect, opData} = '0;
    irqPending = 1'h1;
    instrLow = 7'h55;
    progFetchData = 16'h5A5A;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'h1;
    #1;
    chk(carryFlag_q, 1'h1);
    chk(ramMapSelect_q, 1'h0);
    chk(globalIrqMask_q, 1'h1);
    op(`OP_SST0, 16'h0000, 1'h0, 2'h0);
    settle;
    chk(readData_q, 16'h1E00);
    chk(instrWord_q, 16'h5A5A);
    op(`OP_SST1, 16'h0000, 1'h0, 2'h0);
    settle;
    chk({readValid_q, readData_q}, 17'h1_0FFC);
    foreach (mulRows[i]) begin
      op(`OP_LDTEMP, mulRows[i][95:80], 1'h0, 2'h0);
      op(`OP_SETPM, {14'h0, mulRows[i][97:96]}, 1'h0, 2'h0);
      op(mulRows[i][98] ? `OP_MPYS : `OP_MPYU, mulRows[i][79:64], 1'h0, 2'h0);
      settle;
      chk(productRaw_q, mulRows[i][63:32]);
      chk(productScaled_q, mulRows[i][31:0]);
      chk(productShiftMode_q, mulRows[i][97:96]);
    end
    op(`OP_LDTEMP, 16'h0005, 1'h0, 2'h0);
    settle;
    chk({tempReg_q, dynShiftCount_q, dynBitIndex_q}, 24'h0005_5A);
    op(`OP_LST1, 16'hB003, 1'h0, 2'h0);
    op(`OP_SST1, 16'h0000, 1'h0, 2'h0);
    settle;
    chk({auxPointer_q, auxPointerBackup_q, ramMapSelect_q, carryFlag_q}, 8'hB6);
    chk(readData_q, 16'hBDFF);
    op(`OP_LDPTR, 16'h0002, 1'h0, 2'h0);
    op(`OP_MODAUX, 16'h0006, 1'h0, 2'h0);
    settle;
    chk({auxPointer_q, auxPointerBackup_q}, 6'h32);
    op(`OP_CLRF, 16'h0000, 1'h0, 2'h2);
    op(`OP_LST0, 16'hE3FF, 1'h0, 2'h0);
    settle;
    chk({globalIrqMask_q, irqEnable_q, carryFlag_q}, 3'h2);
    chk({auxPointer_q, auxPointerBackup_q}, 6'h3A);
    chk(directAddr_q, 16'hFFD5);
    for (int i = 0; i < 2; i++) begin
      op(`OP_CLRF, 16'h0000, 1'h0, 2'h2);
      trapTaken <= (i == 0);
      irqAcknowledge <= (i == 1);
      settle;
      chk({globalIrqMask_q, irqEnable_q}, 2'h2);
    end
    op(`OP_CLRF, 16'h0000, 1'h0, 2'h1);
    settle;
    chk({ramMapSelect_q, carryFlag_q}, 2'h0);
    // page load, indirect pointer update, product high-half load under right-six mode
    op(`OP_LDPAGE, 16'hFE12, 1'h0, 2'h0);
    progFetchData <= 16'hC3C3;
    op(`OP_INDIRECT, 16'h0004, 1'h0, 2'h0);
    op(`OP_LDPROD, 16'h1357, 1'h0, 2'h0);
    settle;
    chk(pagePointer_q, 9'h012);
    chk(directAddr_q, 16'h0955);
    chk({auxPointer_q, auxPointerBackup_q}, 6'h27);
    chk(productRaw_q, 32'h1357_0000);
    chk(productScaled_q, 32'h004D_5C00);
    chk(instrWord_q, 16'hC3C3);
    foreach (carryRows[i]) begin
      op(carryRows[i][6:2], 16'h0000, carryRows[i][1], 2'h0);
      settle;
      chk(carryFlag_q, carryRows[i][0]);
    end
    op(`OP_PUSH, 16'h1234, 1'h0, 2'h0);
    op(`OP_PUSH, 16'hBEEF, 1'h0, 2'h0);
    op(`OP_POP, 16'h0000, 1'h0, 2'h0);
    settle;
    chk({stackDepth_q, readValid_q, readData_q}, 20'h3_BEEF);
    op(`OP_POP, 16'h0000, 1'h0, 2'h0);
    settle;
    chk({stackDepth_q, readData_q}, 19'h0_1234);
    @(posedge clk_sys);
    rst_b <= 1'h0;
    #1;
    chk({carryFlag_q, globalIrqMask_q, ramMapSelect_q}, 3'h6);
    complete_run;
  end
endmodule

bind cpu_status_product_path cpu_status_product_path_props props (.clk_sys, .rst_b, .opValid, .opCode,
  .opData, .aluCarry, .irqAcknowledge, .trapTaken, .irqPending, .readValid_q, .readData_q, .auxPointer_q,
  .auxPointerBackup_q, .carryFlag_q, .globalIrqMask_q, .irqEnable_q);
